// File: bus_pin_ctrl.sv
/*
 * Pin-level control of the local bus: buffer direction, locked cycles,
 * hold handshake, coprocessor handshake, upper/lower/generic selects with
 * port fallback. Assumes the core presents one decoded cycle per
 * cycleStart pulse and ranges arrive from elsewhere as plain inputs.
 */
`timescale 1ns/10ps
`include "bus_pins_params.svh"

module bus_pin_ctrl #(
    parameter int ADDR_W = `ADDR_W,
    parameter int GEN_N  = `GEN_COUNT
) (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clkEn,
    input  wire logic                    powerDown,
    input  wire logic                    cycleStart,
    input  wire bus_pins_pkg::cycle_kind_e cycleKind,
    input  wire logic                    cycleWrite,
    input  wire logic                    cycleEnd,
    input  wire logic [ADDR_W-1:0]       cycleAddr,
    input  wire logic                    lockReq,
    input  wire logic                    lockPrefix,
    input  wire logic                    instrBoundary,
    input  wire logic                    numericStart,
    input  wire logic                    holdReq,
    input  wire logic                    coprocErrorN,
    input  wire logic                    coprocXferReqIn,
    input  wire logic                    upperProg,
    input  wire logic [ADDR_W-1:0]       upperLo,
    input  wire logic [ADDR_W-1:0]       upperHi,
    input  wire logic                    upperMemEn,
    input  wire logic                    upperIoEn,
    input  wire logic                    lowerProg,
    input  wire logic [ADDR_W-1:0]       lowerLo,
    input  wire logic [ADDR_W-1:0]       lowerHi,
    input  wire logic [GEN_N-1:0]        genEnable,
    input  wire logic [GEN_N-1:0]        genIsIo,
    input  wire logic [GEN_N*ADDR_W-1:0] genLo,
    input  wire logic [GEN_N*ADDR_W-1:0] genHi,
    input  wire logic                    portWrite,
    input  wire logic [GEN_N-1:0]        portData,
    output logic [GEN_N-1:0]             portReadback,
    output logic                         bufferDirection,
    output logic                         bufferDirectionOe,
    output logic                         lockN,
    output logic                         lockOe,
    output logic                         lockWeakPull,
    output logic                         holdAck,
    output logic                         busFloat,
    output logic                         busGranted,
    output logic                         coprocSelectN,
    output logic                         errorIntReq,
    output logic [7:0]                   errorIntType,
    output logic                         coprocXferRequest,
    output logic                         upperSelectN,
    output logic                         lowerSelectN,
    output logic [GEN_N-1:0]             portOneBitN
);

////////////////////////////////////////////////////////////////////////
    bus_pins_pkg::hold_state_e holdState_q, holdState_d;
    logic                      lock_q, lock_d;
    logic                      dir_q, dir_d;
    logic                      cop_q, cop_d;
    logic                      errInt_q, errInt_d;
    logic                      xfer_q, xfer_d;
    logic [ADDR_W-1:0]         upLo_q, upLo_d, upHi_q, upHi_d;
    logic                      upMem_q, upMem_d, upIo_q, upIo_d;
    logic                      lowArm_q, lowArm_d;
    logic [ADDR_W-1:0]         lowLo_q, lowLo_d, lowHi_q, lowHi_d;
    logic [GEN_N-1:0]          port_q, port_d;
    logic                      inCycle_q, inCycle_d;
    logic                      isMem, isIo, upHit_q, lowHit_q, selQuiet;
    logic [GEN_N-1:0]          genHit_q;

    assign isMem = cycleStart && (cycleKind == bus_pins_pkg::CYC_MEM);
    assign isIo  = cycleStart && (cycleKind == bus_pins_pkg::CYC_IO);

////////////////////////////////////////////////////////////////////////
    // hold handshake and lock
    always_comb begin
        holdState_d = holdState_q;
        lock_d      = lock_q;
        inCycle_d   = inCycle_q;
        if (cycleStart) begin
            inCycle_d = 1'b1;
        end else if (cycleEnd) begin
            inCycle_d = 1'b0;
        end
        if (holdState_q == bus_pins_pkg::BUS_OWNED) begin
            lock_d = lockReq;
        end
        case (holdState_q)
            bus_pins_pkg::BUS_OWNED: begin
                // locked cycles and prefixed instructions keep the bus
                if (holdReq && instrBoundary && !lockPrefix && !lock_q
                    && !lockReq && !inCycle_q && !cycleStart) begin
                    holdState_d = bus_pins_pkg::BUS_FLOAT;
                end
            end
            bus_pins_pkg::BUS_FLOAT: begin
                // outputs float one cycle before the grant is shown
                holdState_d = bus_pins_pkg::BUS_HELD;
            end
            bus_pins_pkg::BUS_HELD: begin
                if (!holdReq) begin
                    holdState_d = bus_pins_pkg::BUS_OWNED;
                end
            end
            default: holdState_d = bus_pins_pkg::BUS_OWNED;
        endcase
        if (powerDown) begin
            holdState_d = bus_pins_pkg::BUS_OWNED;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            holdState_q <= bus_pins_pkg::BUS_OWNED;
            lock_q      <= 1'b0;
            inCycle_q   <= 1'b0;
        end else if (clkEn) begin
            holdState_q <= holdState_d;
            lock_q      <= lock_d;
            inCycle_q   <= inCycle_d;
        end
    end

    assign busFloat   = holdState_q != bus_pins_pkg::BUS_OWNED;
    assign busGranted = holdState_q == bus_pins_pkg::BUS_HELD;
    // acknowledge only after the float state has been in force
    assign holdAck    = busGranted && !sys_rst && !powerDown;

    // lock pin is an input with a weak pull-up while reset holds
    assign lockWeakPull = sys_rst;
    assign lockOe       = !sys_rst && !busFloat;
    assign lockN        = !lock_q;

////////////////////////////////////////////////////////////////////////
    // direction, coprocessor handshake, programmed ranges, port
    always_comb begin
        dir_d    = dir_q;
        cop_d    = 1'b0;
        errInt_d = 1'b0;
        xfer_d   = coprocXferReqIn;
        upLo_d   = upLo_q;
        upHi_d   = upHi_q;
        upMem_d  = upMem_q;
        upIo_d   = upIo_q;
        lowArm_d = lowArm_q;
        lowLo_d  = lowLo_q;
        lowHi_d  = lowHi_q;
        port_d   = port_q;
        if (cycleStart) begin
            dir_d = cycleWrite;
            cop_d = cycleKind == bus_pins_pkg::CYC_COPROC;
        end else if (inCycle_q && !cycleEnd) begin
            cop_d = cop_q;
        end
        if (numericStart && !coprocErrorN) begin
            errInt_d = 1'b1;
        end
        if (upperProg) begin
            upLo_d  = upperLo;
            upHi_d  = upperHi;
            upMem_d = upperMemEn;
            upIo_d  = upperIoEn;
        end
        if (lowerProg) begin
            lowArm_d = 1'b1;
            lowLo_d  = lowerLo;
            lowHi_d  = lowerHi;
        end
        if (portWrite) begin
            port_d = portData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dir_q    <= 1'b0;
            cop_q    <= 1'b0;
            errInt_q <= 1'b0;
            xfer_q   <= 1'b0;
            upLo_q   <= `UPPER_RST_LO;
            upHi_q   <= `UPPER_RST_HI;
            upMem_q  <= 1'b1;
            upIo_q   <= 1'b0;
            lowArm_q <= 1'b0;
            lowLo_q  <= `LOWER_RST_LO;
            lowHi_q  <= `LOWER_RST_HI;
            port_q   <= `PORT_RST;
        end else if (clkEn) begin
            dir_q    <= dir_d;
            cop_q    <= cop_d;
            errInt_q <= errInt_d;
            xfer_q   <= xfer_d;
            upLo_q   <= upLo_d;
            upHi_q   <= upHi_d;
            upMem_q  <= upMem_d;
            upIo_q   <= upIo_d;
            lowArm_q <= lowArm_d;
            lowLo_q  <= lowLo_d;
            lowHi_q  <= lowHi_d;
            port_q   <= port_d;
        end
    end

    assign bufferDirection   = dir_q;
    assign bufferDirectionOe = !busFloat && !sys_rst;
    assign errorIntReq       = errInt_q;
    assign errorIntType      = `ERROR_VECTOR;
    assign coprocXferRequest = xfer_q;

////////////////////////////////////////////////////////////////////////
    // address decode; each hit is held until the cycle end or the next cycle start
    range_match #(.ADDR_W(ADDR_W)) upperMatch (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn && (cycleStart || cycleEnd)),
        .enable   (cycleStart),
        .cycleHit ((isMem && upMem_q) || (isIo && upIo_q)),
        .addr     (cycleAddr),
        .rangeLo  (upLo_q),
        .rangeHi  (upHi_q),
        .match_q  (upHit_q)
    );

    range_match #(.ADDR_W(ADDR_W)) lowerMatch (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn && (cycleStart || cycleEnd)),
        .enable   (lowArm_q && cycleStart),
        .cycleHit (isMem),
        .addr     (cycleAddr),
        .rangeLo  (lowLo_q),
        .rangeHi  (lowHi_q),
        .match_q  (lowHit_q)
    );

    for (genvar g = 0; g < GEN_N; g++) begin : genSel
        range_match #(.ADDR_W(ADDR_W)) genMatch (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .clkEn    (clkEn && (cycleStart || cycleEnd)),
            .enable   (genEnable[g] && cycleStart),
            .cycleHit (genIsIo[g] ? isIo : isMem),
            .addr     (cycleAddr),
            .rangeLo  (genLo[g*ADDR_W +: ADDR_W]),
            .rangeHi  (genHi[g*ADDR_W +: ADDR_W]),
            .match_q  (genHit_q[g])
        );
    end

    // selects go quiet whenever the bus is not ours
    assign selQuiet      = busFloat || sys_rst || powerDown;
    assign upperSelectN  = !(upHit_q && !selQuiet);
    assign lowerSelectN  = !(lowHit_q && !selQuiet);
    assign coprocSelectN = !(cop_q && !selQuiet);

    always_comb begin
        for (int i = 0; i < GEN_N; i++) begin
            if (genEnable[i]) begin
                portOneBitN[i] = !(genHit_q[i] && !selQuiet);
            end else begin
                portOneBitN[i] = port_q[i];
            end
        end
    end

    // software sees the pin level as driven
    assign portReadback = portOneBitN;

////////////////////////////////////////////////////////////////////////
    // a grant that slipped past the lock would show as float next cycle
    property p_lock_blocks_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (lock_q && clkEn) |=> !busFloat;
    endproperty
    a_lock_blocks_hold: assert property (p_lock_blocks_hold)
        else $error("hold granted during locked cycle");

    sequence s_owned;
        holdState_q == bus_pins_pkg::BUS_OWNED;
    endsequence
    sequence s_float;
        holdState_q == bus_pins_pkg::BUS_FLOAT;
    endsequence
    property p_ack_after_float;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(holdAck) |-> $past(busFloat);
    endproperty
    a_ack_after_float: assert property (p_ack_after_float)
        else $error("hold ack without prior float");

    property p_sel_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        busFloat |-> (upperSelectN && lowerSelectN && coprocSelectN);
    endproperty
    a_sel_quiet: assert property (p_sel_quiet)
        else $error("select active while bus held");

    property p_lower_no_io;
        @(posedge core_clk) disable iff (sys_rst)
        (clkEn && isIo) |=> lowerSelectN;
    endproperty
    a_lower_no_io: assert property (p_lower_no_io)
        else $error("lower select on io cycle");

    property p_error_int;
        @(posedge core_clk) disable iff (sys_rst)
        (clkEn && numericStart && !coprocErrorN) |=> errorIntReq;
    endproperty
    a_error_int: assert property (p_error_int)
        else $error("coprocessor error not raised");

    property p_boundary_only;
        @(posedge core_clk) disable iff (sys_rst)
        s_owned ##1 s_float |-> $past(instrBoundary)
            && !$past(lockPrefix);
    endproperty
    a_boundary_only: assert property (p_boundary_only)
        else $error("bus released off boundary");

    property p_lock_float;
        @(posedge core_clk) disable iff (sys_rst)
        busFloat |-> (!lockOe && !bufferDirectionOe);
    endproperty
    a_lock_float: assert property (p_lock_float)
        else $error("lock or direction driven in hold");

    property p_cop_sel;
        @(posedge core_clk) disable iff (sys_rst)
        (clkEn && cycleStart && cycleKind == bus_pins_pkg::CYC_COPROC
            && !busFloat && !powerDown)
            |=> !coprocSelectN || busFloat || powerDown;
    endproperty
    a_cop_sel: assert property (p_cop_sel)
        else $error("coprocessor cycle without select");
endmodule // bus_pin_ctrl

// File: bus_pins_params.svh
/*
 * Timing-free constants for the local bus pin-control block: address
 * widths, reset ranges of the upper select, generic select count.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BUS_PINS_PARAMS_SVH
`define BUS_PINS_PARAMS_SVH

`define ADDR_W          20
`define GEN_COUNT       8
`define UPPER_RST_LO    20'hffc00
`define UPPER_RST_HI    20'hfffff
`define LOWER_RST_LO    20'h00000
`define LOWER_RST_HI    20'h00000
`define ERROR_VECTOR    8'h10
`define PORT_RST        8'hff

`endif

// File: bus_pins_pkg.sv
/*
 * Types shared by the local bus pin-control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bus_pins_pkg;
    typedef enum logic [1:0] {
        BUS_OWNED,
        BUS_FLOAT,
        BUS_HELD
    } hold_state_e;

    typedef enum logic [1:0] {
        CYC_NONE,
        CYC_MEM,
        CYC_IO,
        CYC_COPROC
    } cycle_kind_e;
endpackage

// File: range_match.sv
/*
 * One address range comparator with a registered select flag.
 * Assumes the range and the cycle strobe are stable at the clock edge.
 */
`timescale 1ns/10ps
`include "bus_pins_params.svh"

module range_match #(
    parameter int ADDR_W = `ADDR_W
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    input  wire logic              enable,
    input  wire logic              cycleHit,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [ADDR_W-1:0] rangeLo,
    input  wire logic [ADDR_W-1:0] rangeHi,
    output logic                   match_q
);
    logic matchD;

    always_comb begin
        matchD = enable && cycleHit && (addr >= rangeLo) && (addr <= rangeHi);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            match_q <= 1'b0;
        end else if (clkEn) begin
            match_q <= matchD;
        end
    end
endmodule // range_match

// File: far_side_model.sv
/*
 * Far side of the pin-control block: an external bus master asking for
 * the bus and a numeric coprocessor reporting errors and transfers.
 * Assumes the bench commands it and it sees the block's hold handshake.
 */
`timescale 1ns/10ps
module far_side_model (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic holdAck,
    input  wire logic wantHold,
    input  wire logic errActive,
    input  wire logic xferPending,
    output logic      holdReq,
    output logic      coprocErrorN,
    output logic      coprocXferReqIn
);
    logic holdReq_q, holdReq_d, errN_q, errN_d, xfer_q, xfer_d;

    ////////////////////////////////////////////////////////////
    always_comb begin
        // a master may not withdraw before the grant; it drops only after
        holdReq_d = wantHold | (holdReq_q & ~holdAck);
        errN_d    = ~errActive;
        xfer_d    = xferPending;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            holdReq_q <= 1'h0;
            errN_q    <= 1'h1;
            xfer_q    <= 1'h0;
        end else begin
            holdReq_q <= holdReq_d;
            errN_q    <= errN_d;
            xfer_q    <= xfer_d;
        end
    end

    assign holdReq         = holdReq_q;
    assign coprocErrorN    = errN_q;
    assign coprocXferReqIn = xfer_q;
endmodule // far_side_model

// File: testbench.sv
/*
 * Self-checking bench for the local bus pin-control block.
 * Assumes far_side_model drives the hold and coprocessor inputs.
 */
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, powerDown = 1'h0;
    logic cycleStart = 1'h0, cycleWrite = 1'h0, cycleEnd = 1'h0;
    logic lockReq = 1'h0, lockPrefix = 1'h0, instrBoundary = 1'h1;
    logic numericStart = 1'h0, upperProg = 1'h0, upperMemEn = 1'h0;
    logic upperIoEn = 1'h0, lowerProg = 1'h0, portWrite = 1'h0;
    logic wantHold = 1'h0, errActive = 1'h0, xferPending = 1'h0;
    logic [19:0]  cycleAddr = 20'h00000, upperLo = 20'h00000;
    logic [19:0]  upperHi = 20'h00000, lowerLo = 20'h00000;
    logic [19:0]  lowerHi = 20'h00000;
    logic [7:0]   genEnable = 8'hff, genIsIo = 8'haa, portData = 8'h00;
    logic [159:0] genLo, genHi;
    bus_pins_pkg::cycle_kind_e cycleKind = bus_pins_pkg::CYC_NONE;
    logic holdReq, coprocErrorN, coprocXferReqIn, bufferDirection;
    logic bufferDirectionOe, lockN, lockOe, lockWeakPull, holdAck, busFloat;
    logic busGranted, coprocSelectN, errorIntReq, coprocXferRequest;
    logic upperSelectN, lowerSelectN;
    logic [7:0] portReadback, portOneBitN, errorIntType;
    int   errCount = 0, samplesChecked = 0;

    always #20 core_clk = ~core_clk;

    far_side_model u_far (.core_clk(core_clk), .sys_rst(sys_rst),
        .holdAck(holdAck), .wantHold(wantHold), .errActive(errActive),
        .xferPending(xferPending), .holdReq(holdReq),
        .coprocErrorN(coprocErrorN), .coprocXferReqIn(coprocXferReqIn));

    bus_pin_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .clkEn(clkEn), .powerDown(powerDown), .cycleStart(cycleStart),
        .cycleKind(cycleKind), .cycleWrite(cycleWrite), .cycleEnd(cycleEnd),
        .cycleAddr(cycleAddr), .lockReq(lockReq), .lockPrefix(lockPrefix),
        .instrBoundary(instrBoundary), .numericStart(numericStart),
        .holdReq(holdReq), .coprocErrorN(coprocErrorN),
        .coprocXferReqIn(coprocXferReqIn), .upperProg(upperProg),
        .upperLo(upperLo), .upperHi(upperHi), .upperMemEn(upperMemEn),
        .upperIoEn(upperIoEn), .lowerProg(lowerProg), .lowerLo(lowerLo),
        .lowerHi(lowerHi), .genEnable(genEnable), .genIsIo(genIsIo),
        .genLo(genLo), .genHi(genHi), .portWrite(portWrite),
        .portData(portData), .portReadback(portReadback),
        .bufferDirection(bufferDirection),
        .bufferDirectionOe(bufferDirectionOe), .lockN(lockN),
        .lockOe(lockOe), .lockWeakPull(lockWeakPull), .holdAck(holdAck),
        .busFloat(busFloat), .busGranted(busGranted),
        .coprocSelectN(coprocSelectN), .errorIntReq(errorIntReq),
        .errorIntType(errorIntType), .coprocXferRequest(coprocXferRequest),
        .upperSelectN(upperSelectN), .lowerSelectN(lowerSelectN),
        .portOneBitN(portOneBitN));

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s seen %h want %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // cycle is taken at the second edge; selects are sampled just after it
    task automatic run_cycle(input bus_pins_pkg::cycle_kind_e k,
                             input logic w, input logic [19:0] a);
        @(posedge core_clk);
        cycleStart <= 1'h1;
        cycleKind  <= k;
        cycleWrite <= w;
        cycleAddr  <= a;
        @(posedge core_clk);
        cycleStart <= 1'h0;
        #1;
    endtask

    task automatic end_cycle;
        @(posedge core_clk);
        cycleEnd <= 1'h1;
        @(posedge core_clk);
        cycleEnd <= 1'h0;
        #1;
    endtask

    task automatic timed_out(input string msg);
        errCount++;
        $display("CHECK FAILED at %0t: %s never came", $time, msg);
        print_verdict();
    endtask

    ////////////////////////////////////////////////////////////
    task automatic reset_values;
        repeat (15) @(posedge core_clk);
        #1;
        check(lockWeakPull, 1'h1, "lock pull in reset");
        check(lockOe, 1'h0, "lock driven in reset");
        check(holdAck, 1'h0, "ack in reset");
        check(upperSelectN, 1'h1, "upper in reset");
        check(lowerSelectN, 1'h1, "lower in reset");
        check(coprocSelectN, 1'h1, "coproc sel in reset");
        check(portOneBitN, 8'hff, "pins in reset");
        @(posedge core_clk);
        sys_rst <= 1'h0;
        @(posedge core_clk);
        #1;
        check(lockWeakPull, 1'h0, "lock pull after reset");
    endtask

    task automatic upper_decode;
        bus_pins_pkg::cycle_kind_e k[4];
        logic [19:0] a[4];
        logic [3:0]  hit;
        k   = '{bus_pins_pkg::CYC_MEM, bus_pins_pkg::CYC_MEM,
                bus_pins_pkg::CYC_MEM, bus_pins_pkg::CYC_IO};
        a   = '{20'hffc00, 20'hfffff, 20'hffbff, 20'hffc00};
        hit = 4'h3;
        for (int i = 0; i < 4; i++) begin
            run_cycle(k[i], i[0], a[i]);
            check(upperSelectN, !hit[i], "upper reset range");
            check(bufferDirection, i[0], "direction");
            check(bufferDirectionOe, 1'h1, "direction drive");
            end_cycle();
            check(upperSelectN, 1'h1, "upper after end");
        end
    endtask

    task automatic upper_prog;
        @(posedge core_clk);
        upperProg  <= 1'h1;
        upperLo    <= 20'h10000;
        upperHi    <= 20'h100ff;
        upperIoEn  <= 1'h1;
        @(posedge core_clk);
        upperProg <= 1'h0;
        run_cycle(bus_pins_pkg::CYC_IO, 1'h0, 20'h100ff);
        check(upperSelectN, 1'h0, "upper io hit");
        @(posedge core_clk);
        powerDown <= 1'h1;
        @(posedge core_clk);
        #1;
        check(upperSelectN, 1'h1, "upper in powerdown");
        check(holdAck, 1'h0, "ack in powerdown");
        @(posedge core_clk);
        powerDown <= 1'h0;
        end_cycle();
        run_cycle(bus_pins_pkg::CYC_MEM, 1'h0, 20'h100ff);
        check(upperSelectN, 1'h1, "upper mem disabled");
        run_cycle(bus_pins_pkg::CYC_IO, 1'h0, 20'h10100);
        check(upperSelectN, 1'h1, "upper above range");
        end_cycle();
    endtask

    task automatic lower_decode;
        run_cycle(bus_pins_pkg::CYC_MEM, 1'h0, 20'h00000);
        check(lowerSelectN, 1'h1, "lower unprogrammed");
        end_cycle();
        @(posedge core_clk);
        lowerProg <= 1'h1;
        lowerHi   <= 20'h003ff;
        @(posedge core_clk);
        lowerProg <= 1'h0;
        run_cycle(bus_pins_pkg::CYC_MEM, 1'h0, 20'h003ff);
        check(lowerSelectN, 1'h0, "lower mem hit");
        run_cycle(bus_pins_pkg::CYC_IO, 1'h0, 20'h003ff);
        check(lowerSelectN, 1'h1, "lower io ignored");
        run_cycle(bus_pins_pkg::CYC_MEM, 1'h0, 20'h00400);
        check(lowerSelectN, 1'h1, "lower above range");
        run_cycle(bus_pins_pkg::CYC_COPROC, 1'h1, 20'h000f8);
        check(coprocSelectN, 1'h0, "coproc select");
        check(bufferDirection, 1'h1, "coproc write dir");
        end_cycle();
        check(coprocSelectN, 1'h1, "coproc select end");
    endtask

    task automatic generic_pins;
        // back-to-back starts: each new cycle must clear the last pin
        for (int g = 0; g < 8; g++) begin
            run_cycle(g[0] ? bus_pins_pkg::CYC_IO : bus_pins_pkg::CYC_MEM,
                      1'h0, {g[3:0], 16'h80ff});
            check(portOneBitN, ~(8'h01 << g), "generic hit");
        end
        run_cycle(bus_pins_pkg::CYC_MEM, 1'h0, {4'h1, 16'h8000});
        check(portOneBitN, 8'hff, "generic wrong kind");
        end_cycle();
        @(posedge core_clk);
        genEnable <= 8'h0f;
        portWrite <= 1'h1;
        portData  <= 8'ha5;
        @(posedge core_clk);
        portWrite <= 1'h0;
        #1;
        check(portOneBitN, 8'haf, "mixed pins");
        @(posedge core_clk);
        genEnable <= 8'h00;
        @(posedge core_clk);
        #1;
        check(portOneBitN, 8'ha5, "port pins");
        check(portReadback, 8'ha5, "port readback");
    endtask

    task automatic hold_grant;
        logic floatSeen;
        int   n;
        @(posedge core_clk);
        lockReq  <= 1'h1;
        wantHold <= 1'h1;
        repeat (6) @(posedge core_clk);
        #1;
        check(lockN, 1'h0, "lock asserted");
        check(holdAck, 1'h0, "grant under lock");
        @(posedge core_clk);
        lockReq    <= 1'h0;
        lockPrefix <= 1'h1;
        repeat (6) @(posedge core_clk);
        #1;
        check(busFloat, 1'h0, "float under prefix");
        check(holdAck, 1'h0, "grant under prefix");
        @(posedge core_clk);
        lockPrefix    <= 1'h0;
        instrBoundary <= 1'h0;
        repeat (6) @(posedge core_clk);
        #1;
        check(holdAck, 1'h0, "grant off boundary");
        @(posedge core_clk);
        instrBoundary <= 1'h1;
        floatSeen = 1'h0;
        for (n = 0; n < 20 && holdAck !== 1'h1; n++) begin
            floatSeen = busFloat;
            @(posedge core_clk);
            #1;
        end
        if (holdAck !== 1'h1)
            timed_out("hold grant");
        check(floatSeen, 1'h1, "float before ack");
        check(busGranted, 1'h1, "bus granted");
        check(lockOe, 1'h0, "lock floated");
        check(bufferDirectionOe, 1'h0, "direction floated");
        run_cycle(bus_pins_pkg::CYC_MEM, 1'h0, 20'h003ff);
        check(lowerSelectN, 1'h1, "select in hold");
        end_cycle();
        @(posedge core_clk);
        wantHold <= 1'h0;
        for (n = 0; n < 20 && (holdAck | busFloat) !== 1'h0; n++) begin
            @(posedge core_clk);
            #1;
        end
        if ((holdAck | busFloat) !== 1'h0)
            timed_out("hold release");
        check(bufferDirectionOe, 1'h1, "direction back");
    endtask

    task automatic coproc_events;
        @(posedge core_clk);
        errActive <= 1'h1;
        repeat (2) @(posedge core_clk);
        numericStart <= 1'h1;
        @(posedge core_clk);
        numericStart <= 1'h0;
        #1;
        check(errorIntReq, 1'h1, "error interrupt");
        check(errorIntType, 8'h10, "interrupt type");
        @(posedge core_clk);
        errActive   <= 1'h0;
        xferPending <= 1'h1;
        #1;
        check(errorIntReq, 1'h0, "interrupt pulse");
        // one edge through the partner's flop, one through the block's
        repeat (2) @(posedge core_clk);
        #1;
        check(coprocXferRequest, 1'h1, "transfer request");
        @(posedge core_clk);
        numericStart <= 1'h1;
        xferPending  <= 1'h0;
        @(posedge core_clk);
        numericStart <= 1'h0;
        @(posedge core_clk);
        #1;
        check(errorIntReq, 1'h0, "no error interrupt");
        check(coprocXferRequest, 1'h0, "transfer done");
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        for (int g = 0; g < 8; g++) begin
            genLo[g*20 +: 20] = {g[3:0], 16'h8000};
            genHi[g*20 +: 20] = {g[3:0], 16'h80ff};
        end
        reset_values();
        upper_decode();
        upper_prog();
        lower_decode();
        hold_grant();
        generic_pins();
        coproc_events();
        print_verdict();
    end
endmodule // testbench
